// *** rtl/tcu_pkg.sv ***
// Shared constants for the 8-bit timer counter unit
package tcu_pkg;
  // Register bus geometry and count width
  localparam int          TCU_ADR_W      = 5;
  localparam int          TCU_DAT_W      = 32;
  localparam int          TCU_CNT_W      = 8;
  // Register byte offsets
  localparam logic [4:0]  TCU_OFF_CTRL_A = 5'h00;
  localparam logic [4:0]  TCU_OFF_CTRL_B = 5'h04;
  localparam logic [4:0]  TCU_OFF_COUNT  = 5'h08;
  localparam logic [4:0]  TCU_OFF_CMP_A  = 5'h0C;
  localparam logic [4:0]  TCU_OFF_CMP_B  = 5'h10;
  localparam logic [4:0]  TCU_OFF_FLAGS  = 5'h14;
  localparam logic [4:0]  TCU_OFF_MASK   = 5'h18;
  // Field positions
  localparam int          TCU_FLD_WM_LO  = 0;
  localparam int          TCU_FLD_CS_LO  = 0;
  localparam int          TCU_FLD_WM2    = 3;
  localparam int          TCU_FLG_OVF    = 0;
  localparam int          TCU_FLG_MA     = 1;
  localparam int          TCU_FLG_MB     = 2;
  // Values after reset
  localparam logic [7:0]  TCU_RST_BYTE   = 8'h00;
  localparam logic [2:0]  TCU_RST_FLAGS  = 3'h0;
  localparam logic [9:0]  TCU_RST_PRESC  = 10'h000;
  // Count limits
  localparam logic [7:0]  TCU_BOTTOM     = 8'h00;
  localparam logic [7:0]  TCU_MAX        = 8'hFF;
  // Clock select codes
  localparam logic [2:0]  TCU_CS_NONE    = 3'h0;
  localparam logic [2:0]  TCU_CS_DIV1    = 3'h1;
  localparam logic [2:0]  TCU_CS_DIV8    = 3'h2;
  localparam logic [2:0]  TCU_CS_DIV64   = 3'h3;
  localparam logic [2:0]  TCU_CS_DIV256  = 3'h4;
  localparam logic [2:0]  TCU_CS_DIV1024 = 3'h5;
  localparam logic [2:0]  TCU_CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  TCU_CS_EXT_RISE = 3'h7;
  // Prescaler tap widths (divide by two to the power)
  localparam int          TCU_TAP_DIV8    = 3;
  localparam int          TCU_TAP_DIV64   = 6;
  localparam int          TCU_TAP_DIV256  = 8;
  localparam int          TCU_TAP_DIV1024 = 10;
  // Waveform modes
  localparam logic [2:0]  TCU_WM_NORMAL   = 3'h0;
  localparam logic [2:0]  TCU_WM_PC_MAX   = 3'h1;
  localparam logic [2:0]  TCU_WM_CTC      = 3'h2;
  localparam logic [2:0]  TCU_WM_FAST_MAX = 3'h3;
  localparam logic [2:0]  TCU_WM_PC_CMPA  = 3'h5;
  localparam logic [2:0]  TCU_WM_FAST_CMPA = 3'h7;
endpackage

// *** rtl/tcu_tick_gen.sv ***
// Clock select: prescaler taps or synchronised external pin edge as a tick enable
module tcu_tick_gen (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Selection
  input  wire logic [2:0]           clock_select,
  // External pin, asynchronous
  input  wire logic                 ext_clock_pin,
  // Tick enable
  output logic                      timer_tick
);
  import tcu_pkg::*;

  typedef struct packed {
    logic [9:0] presc;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_s3;
  } tcu_tick_state_type;

  tcu_tick_state_type st;
  tcu_tick_state_type next_st;

  function automatic logic tap_hit(input logic [9:0] cnt, input int bits);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < bits; i++) begin
      hit = hit & cnt[i];
    end
    return hit;
  endfunction

  always_comb begin
    next_st        = st;
    // Free-running prescaler, shared by the /8, /64, /256 and /1024 rates
    next_st.presc  = st.presc + 10'h001;
    next_st.pin_s1 = ext_clock_pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edge detection reads only the second and third stages
  always_comb begin
    case (clock_select)
      TCU_CS_NONE:     timer_tick = 1'b0;
      TCU_CS_DIV1:     timer_tick = 1'b1;
      TCU_CS_DIV8:     timer_tick = tap_hit(st.presc, TCU_TAP_DIV8);
      TCU_CS_DIV64:    timer_tick = tap_hit(st.presc, TCU_TAP_DIV64);
      TCU_CS_DIV256:   timer_tick = tap_hit(st.presc, TCU_TAP_DIV256);
      TCU_CS_DIV1024:  timer_tick = tap_hit(st.presc, TCU_TAP_DIV1024);
      TCU_CS_EXT_FALL: timer_tick = st.pin_s3 & ~st.pin_s2;
      default:         timer_tick = st.pin_s2 & ~st.pin_s3;
    endcase
  end
endmodule

// *** rtl/tcu_timer.sv ***
// Timer counter unit: count register, two compare channels, flags, Wishbone slave
// Notes on behaviour
// - Count value and both compare values are eight bits wide.
// - Every interrupt request shows as a bit in the flag register.
// - Each request is gated by its own mask bit.
// - Counter ticks from the internal prescaler or the external pin.
// - Clock select picks source and edge; its output is the tick.
// - Clock select zero means no tick: the counter stops.
// - Both compare values are compared with the count at all times.
// - A compare match sets that channel's flag.
// - Bottom is count 0x00, max is count 0xFF.
// - Top is 0xFF or compare A, chosen by mode.
// - Each tick clears, increments or decrements the count per mode and direction.
// - Software reads and writes the count with or without ticks.
// - A software count write beats any clear or count that cycle.
// - Mode comes from two bits in control A and one in control B.
// - Overflow flag is set at mode-defined points and can request an interrupt.
// - The clear signal zeroes every count bit.
// - Top and bottom indications are given for the count.
// - Compare values are double buffered.
// - Buffering applies only in PWM modes; otherwise writes are direct.
// - Normal mode counts up, wraps 0xFF to 0x00, sets overflow then.
// - Clear-on-match mode clears the count when it equals compare A.
module tcu_timer (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // Wishbone classic slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [tcu_pkg::TCU_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [tcu_pkg::TCU_DAT_W-1:0] wb_dat_i,
  output logic      [tcu_pkg::TCU_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  // External clock pin
  input  wire logic                          ext_clock_pin,
  // Interrupt requests: overflow, match A, match B
  output logic      [2:0]                    timer_irq_req,
  // Waveform generator side
  output logic                               match_a_pulse,
  output logic                               match_b_pulse,
  output logic                               count_at_top,
  output logic                               count_at_bottom,
  output logic                               count_at_max,
  output logic                               count_down
);
  import tcu_pkg::*;

  typedef struct packed {
    logic [7:0] count_value;
    logic       dir_down;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [1:0] timer_ctrl_a;
    logic [3:0] timer_ctrl_b;
    logic [2:0] timer_irq_flags;
    logic [2:0] timer_irq_mask;
    logic       block;
    logic       ack;
    logic [7:0] rdata;
    logic       hit_a;
    logic       hit_b;
  } tcu_state_type;

  tcu_state_type st;
  tcu_state_type next_st;

  logic       timer_tick;
  logic [2:0] clock_select;
  logic [2:0] wave_mode;
  logic       pwm_mode;
  logic       phase_mode;
  logic [7:0] top_value;
  logic       eq_a;
  logic       eq_b;
  logic       at_top;
  logic       ovf_event;
  logic       wr_go;
  logic       wr_count;
  logic       wr_cmp_a;
  logic       wr_cmp_b;
  logic       clear_count;
  logic [7:0] wbyte;

  function automatic logic [7:0] top_of(input logic [2:0] mode, input logic [7:0] cmp_a);
    if (mode == TCU_WM_CTC || mode == TCU_WM_PC_CMPA || mode == TCU_WM_FAST_CMPA) begin
      return cmp_a;
    end else begin
      return TCU_MAX;
    end
  endfunction

  tcu_tick_gen u_tick (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .clock_select  (clock_select),
    .ext_clock_pin (ext_clock_pin),
    .timer_tick    (timer_tick)
  );

  // Mode decode
  assign clock_select = st.timer_ctrl_b[TCU_FLD_CS_LO +: 3];
  assign wave_mode    = {st.timer_ctrl_b[TCU_FLD_WM2],
                         st.timer_ctrl_a[TCU_FLD_WM_LO +: 2]};
  assign pwm_mode     = wave_mode[0];
  assign phase_mode   = (wave_mode == TCU_WM_PC_MAX) || (wave_mode == TCU_WM_PC_CMPA);
  assign top_value    = top_of(wave_mode, st.compare_a_value);
  assign eq_a         = (st.count_value == st.compare_a_value);
  assign eq_b         = (st.count_value == st.compare_b_value);
  assign at_top       = (st.count_value == top_value);

  // Bus write strobe: a write lands on the edge where the master sees ack
  assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & st.ack & wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign wr_count = wr_go && (wb_adr_i == TCU_OFF_COUNT);
  assign wr_cmp_a = wr_go && (wb_adr_i == TCU_OFF_CMP_A);
  assign wr_cmp_b = wr_go && (wb_adr_i == TCU_OFF_CMP_B);

  always_comb begin
    next_st     = st;
    ovf_event   = 1'b0;
    clear_count = 1'b0;
    next_st.hit_a = 1'b0;
    next_st.hit_b = 1'b0;
    // Counting happens only on a tick, never on its own clock
    if (timer_tick) begin
      if (phase_mode) begin
        if (!st.dir_down && at_top) begin
          next_st.dir_down    = 1'b1;
          next_st.count_value = st.count_value - 8'h01;
        end else if (st.dir_down && st.count_value == TCU_BOTTOM) begin
          next_st.dir_down    = 1'b0;
          next_st.count_value = st.count_value + 8'h01;
          ovf_event           = 1'b1;
        end else if (st.dir_down) begin
          next_st.count_value = st.count_value - 8'h01;
        end else begin
          next_st.count_value = st.count_value + 8'h01;
        end
      end else begin
        next_st.dir_down = 1'b0;
        if (wave_mode == TCU_WM_CTC) begin
          clear_count = eq_a;
          ovf_event   = (st.count_value == TCU_MAX);
        end else if (pwm_mode) begin
          clear_count = at_top;
          ovf_event   = at_top;
        end else begin
          ovf_event   = (st.count_value == TCU_MAX);
        end
        if (clear_count) begin
          next_st.count_value = TCU_BOTTOM;
        end else begin
          next_st.count_value = st.count_value + 8'h01;
        end
      end
      // Match is seen on the tick after a count write only if not blocked
      next_st.hit_a = eq_a & ~st.block;
      next_st.hit_b = eq_b & ~st.block;
      next_st.block = 1'b0;
      // Buffered compare values move over at top so no odd pulse appears
      if (pwm_mode && at_top && !st.dir_down) begin
        next_st.compare_a_value = st.buf_a;
        next_st.compare_b_value = st.buf_b;
      end
    end

    // Bus answer: ack one cycle after the request, read data with it
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      if (wb_adr_i == TCU_OFF_CTRL_A) begin
        next_st.rdata = {6'h00, st.timer_ctrl_a};
      end else if (wb_adr_i == TCU_OFF_CTRL_B) begin
        next_st.rdata = {4'h0, st.timer_ctrl_b};
      end else if (wb_adr_i == TCU_OFF_COUNT) begin
        next_st.rdata = st.count_value;
      end else if (wb_adr_i == TCU_OFF_CMP_A) begin
        next_st.rdata = st.buf_a;
      end else if (wb_adr_i == TCU_OFF_CMP_B) begin
        next_st.rdata = st.buf_b;
      end else if (wb_adr_i == TCU_OFF_FLAGS) begin
        next_st.rdata = {5'h00, st.timer_irq_flags};
      end else if (wb_adr_i == TCU_OFF_MASK) begin
        next_st.rdata = {5'h00, st.timer_irq_mask};
      end else begin
        next_st.rdata = TCU_RST_BYTE;
      end
    end

    if (wr_go && wb_adr_i == TCU_OFF_CTRL_A) begin
      next_st.timer_ctrl_a = wbyte[1:0];
    end
    if (wr_go && wb_adr_i == TCU_OFF_CTRL_B) begin
      next_st.timer_ctrl_b = wbyte[3:0];
    end
    if (wr_go && wb_adr_i == TCU_OFF_MASK) begin
      next_st.timer_irq_mask = wbyte[2:0];
    end
    // Software count write overrides clear and count, and blocks the next match
    if (wr_count) begin
      next_st.count_value = wbyte;
      next_st.block       = 1'b1;
    end
    if (wr_cmp_a) begin
      next_st.buf_a = wbyte;
      if (!pwm_mode) begin
        next_st.compare_a_value = wbyte;
      end
    end
    if (wr_cmp_b) begin
      next_st.buf_b = wbyte;
      if (!pwm_mode) begin
        next_st.compare_b_value = wbyte;
      end
    end
    // Leaving PWM the buffer must not hold a stale value over direct writes
    if (!pwm_mode && !wr_cmp_a) begin
      next_st.buf_a = next_st.compare_a_value;
    end
    if (!pwm_mode && !wr_cmp_b) begin
      next_st.buf_b = next_st.compare_b_value;
    end

    // Flags clear by writing one; a set in the same cycle wins
    next_st.timer_irq_flags = st.timer_irq_flags;
    if (wr_go && wb_adr_i == TCU_OFF_FLAGS) begin
      next_st.timer_irq_flags = st.timer_irq_flags & ~wbyte[2:0];
    end
    if (ovf_event) begin
      next_st.timer_irq_flags[TCU_FLG_OVF] = 1'b1;
    end
    if (st.hit_a) begin
      next_st.timer_irq_flags[TCU_FLG_MA] = 1'b1;
    end
    if (st.hit_b) begin
      next_st.timer_irq_flags[TCU_FLG_MB] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o        = st.ack;
  assign wb_dat_o        = {24'h000000, st.rdata};
  assign timer_irq_req   = st.timer_irq_flags & st.timer_irq_mask;
  assign match_a_pulse   = st.hit_a;
  assign match_b_pulse   = st.hit_b;
  assign count_at_top    = at_top;
  assign count_at_bottom = (st.count_value == TCU_BOTTOM);
  assign count_at_max    = (st.count_value == TCU_MAX);
  assign count_down      = st.dir_down;

  property p_count_write;
    @(posedge core_clk) disable iff (sys_rst)
      wr_count |=> st.count_value == $past(wbyte);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_stopped;
    @(posedge core_clk) disable iff (sys_rst)
      (clock_select == TCU_CS_NONE) && !wr_count |=> $stable(st.count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_normal_wrap;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && wave_mode == TCU_WM_NORMAL && st.count_value == TCU_MAX && !wr_count
      |=> st.count_value == TCU_BOTTOM && st.timer_irq_flags[TCU_FLG_OVF];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_ctc_clear;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && wave_mode == TCU_WM_CTC && eq_a && !wr_count
      |=> st.count_value == TCU_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match");

  property p_normal_inc;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && wave_mode == TCU_WM_NORMAL && !wr_count
      |=> st.count_value == $past(st.count_value) + 8'h01;
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("no increment");

  property p_match_flag;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && eq_a && !st.block ##1 !wr_go |=> st.timer_irq_flags[TCU_FLG_MA];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match A flag missing");

  property p_irq_gate;
    @(posedge core_clk) disable iff (sys_rst)
      !st.timer_irq_mask[TCU_FLG_OVF] |-> !timer_irq_req[TCU_FLG_OVF];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked request raised");

  property p_direct_cmp;
    @(posedge core_clk) disable iff (sys_rst)
      wr_cmp_a && !pwm_mode |=> st.compare_a_value == $past(wbyte);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare write lost");

  property p_buffered_cmp;
    @(posedge core_clk) disable iff (sys_rst)
      pwm_mode && wr_cmp_a && !(timer_tick && at_top) |=> $stable(st.compare_a_value);
  endproperty
  a_buffered_cmp: assert property (p_buffered_cmp) else $error("buffer bypassed");

  property p_flag_read;
    @(posedge core_clk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && !st.ack && wb_adr_i == TCU_OFF_FLAGS
      |=> wb_ack_o && wb_dat_o[2:0] == $past(st.timer_irq_flags);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_phase_bottom;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && phase_mode && st.dir_down && st.count_value == TCU_BOTTOM && !wr_count
      |=> !st.dir_down && st.timer_irq_flags[TCU_FLG_OVF];
  endproperty
  a_phase_bottom: assert property (p_phase_bottom) else $error("no turn at bottom");

  property p_fast_top;
    @(posedge core_clk) disable iff (sys_rst)
      timer_tick && pwm_mode && !phase_mode && at_top && !wr_count
      |=> st.count_value == TCU_BOTTOM;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast mode missed top");

  c_overflow: cover property (@(posedge core_clk) disable iff (sys_rst)
    ovf_event && wave_mode == TCU_WM_NORMAL);
  c_ctc: cover property (@(posedge core_clk) disable iff (sys_rst)
    timer_tick && clear_count && wave_mode == TCU_WM_CTC);
  c_phase_turn: cover property (@(posedge core_clk) disable iff (sys_rst)
    phase_mode && ovf_event);
  c_match_b: cover property (@(posedge core_clk) disable iff (sys_rst) st.hit_b);
endmodule

// *** sim/tcu_testbench.sv ***
// Self-checking bench for the timer counter unit, driven over Wishbone and the external pin
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tcu_pkg::*;

  logic                 core_clk;
  logic                 sys_rst;
  logic                 wb_cyc_i;
  logic                 wb_stb_i;
  logic                 wb_we_i;
  logic [TCU_ADR_W-1:0] wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [TCU_DAT_W-1:0] wb_dat_i;
  logic [TCU_DAT_W-1:0] wb_dat_o;
  logic                 wb_ack_o;
  logic                 ext_clock_pin;
  logic [2:0]           timer_irq_req;
  logic                 match_a_pulse;
  logic                 match_b_pulse;
  logic                 count_at_top;
  logic                 count_at_bottom;
  logic                 count_at_max;
  logic                 count_down;
  int                   fail_count;
  int                   num_checks;
  int                   hits_a;
  int                   hits_b;
  logic [31:0]          rd;

  tcu_timer tcu_timer_i (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .ext_clock_pin   (ext_clock_pin),
    .timer_irq_req   (timer_irq_req),
    .match_a_pulse   (match_a_pulse),
    .match_b_pulse   (match_b_pulse),
    .count_at_top    (count_at_top),
    .count_at_bottom (count_at_bottom),
    .count_at_max    (count_at_max),
    .count_down      (count_down)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Hit pulses stand one cycle, so they are counted at every edge
  always @(posedge core_clk) begin
    if (match_a_pulse === 1'b1) hits_a++;
    if (match_b_pulse === 1'b1) hits_b++;
  end

  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; entered just after a rising edge, leaves one idle cycle behind
  task automatic wb_xfer(input logic we, input logic [4:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // No cycle count is assumed; a missing ack is caught by the watchdog
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // Pin held long enough for the synchroniser to see both edges
  task automatic pulse(input int k);
    repeat (k) begin
      ext_clock_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask

  task automatic t_reset();
    logic [4:0] offs [7];
    offs = '{TCU_OFF_CTRL_A, TCU_OFF_CTRL_B, TCU_OFF_COUNT, TCU_OFF_CMP_A,
             TCU_OFF_CMP_B, TCU_OFF_FLAGS, TCU_OFF_MASK};
    foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0000_0000);
    rd_chk("unmapped", 5'h1C, 32'h0000_0000);
    check("bottom after reset", count_at_bottom, 1'b1);
    check("irq after reset", timer_irq_req, 3'h0);
  endtask

  task automatic t_stopped();
    wr(TCU_OFF_COUNT, 32'h0000_01A5);
    repeat (20) @(posedge core_clk);
    rd_chk("count width and hold", TCU_OFF_COUNT, 32'h0000_00A5);
  endtask

  task automatic t_normal();
    wr(TCU_OFF_CTRL_B, 32'h0000_0007);
    wr(TCU_OFF_COUNT, 32'h0000_00FE);
    wr(TCU_OFF_FLAGS, 32'h0000_0007);
    pulse(1);
    check("max at 0xFF", count_at_max, 1'b1);
    pulse(1);
    check("bottom after wrap", count_at_bottom, 1'b1);
    rd_chk("overflow flag", TCU_OFF_FLAGS, 32'h0000_0001);
    wr(TCU_OFF_MASK, 32'h0000_0001);
    check("overflow irq", timer_irq_req, 3'h1);
    wr(TCU_OFF_MASK, 32'h0000_0000);
    check("masked irq", timer_irq_req, 3'h0);
    wr(TCU_OFF_FLAGS, 32'h0000_0001);
    rd_chk("flag cleared", TCU_OFF_FLAGS, 32'h0000_0000);
  endtask

  task automatic t_match();
    wr(TCU_OFF_CMP_A, 32'h0000_0003);
    wr(TCU_OFF_CMP_B, 32'h0000_0005);
    wr(TCU_OFF_COUNT, 32'h0000_0000);
    hits_a = 0;
    hits_b = 0;
    pulse(4);
    check("hits on A", hits_a, 1);
    rd_chk("flag A only", TCU_OFF_FLAGS, 32'h0000_0002);
    // Falling-edge selection must count the same pulses
    wr(TCU_OFF_CTRL_B, 32'h0000_0006);
    pulse(2);
    check("hits on B", hits_b, 1);
    rd_chk("flags A and B", TCU_OFF_FLAGS, 32'h0000_0006);
    wr(TCU_OFF_MASK, 32'h0000_0004);
    check("irq B only", timer_irq_req, 3'h4);
    wr(TCU_OFF_MASK, 32'h0000_0000);
    wr(TCU_OFF_FLAGS, 32'h0000_0007);
  endtask

  task automatic t_ctc();
    wr(TCU_OFF_CTRL_A, 32'h0000_0002);
    wr(TCU_OFF_CTRL_B, 32'h0000_0007);
    wr(TCU_OFF_CMP_A, 32'h0000_0002);
    wr(TCU_OFF_COUNT, 32'h0000_0000);
    pulse(2);
    check("top at compare A", count_at_top, 1'b1);
    pulse(1);
    rd_chk("cleared at match", TCU_OFF_COUNT, 32'h0000_0000);
  endtask

  task automatic t_fast();
    wr(TCU_OFF_CMP_A, 32'h0000_0004);
    wr(TCU_OFF_CTRL_A, 32'h0000_0003);
    wr(TCU_OFF_CTRL_B, 32'h0000_000F);
    wr(TCU_OFF_COUNT, 32'h0000_0000);
    wr(TCU_OFF_CMP_A, 32'h0000_0002);
    rd_chk("buffer readback", TCU_OFF_CMP_A, 32'h0000_0002);
    pulse(2);
    check("old top still active", count_at_top, 1'b0);
    pulse(2);
    check("top at old value", count_at_top, 1'b1);
    pulse(3);
    check("top after reload", count_at_top, 1'b1);
  endtask

  task automatic t_phase();
    wr(TCU_OFF_CTRL_A, 32'h0000_0001);
    wr(TCU_OFF_CTRL_B, 32'h0000_0007);
    wr(TCU_OFF_COUNT, 32'h0000_00FE);
    pulse(2);
    check("turned down", count_down, 1'b1);
    rd_chk("decremented", TCU_OFF_COUNT, 32'h0000_00FE);
    wr(TCU_OFF_FLAGS, 32'h0000_0007);
    wr(TCU_OFF_COUNT, 32'h0000_0001);
    pulse(2);
    check("turned up at bottom", count_down, 1'b0);
    rd_chk("overflow at bottom", TCU_OFF_FLAGS, 32'h0000_0001);
  endtask

  task automatic t_priority();
    wr(TCU_OFF_CTRL_A, 32'h0000_0000);
    wr(TCU_OFF_CTRL_B, 32'h0000_0001);
    wr(TCU_OFF_COUNT, 32'h0000_0010);
    wr(TCU_OFF_COUNT, 32'h0000_0080);
    wr(TCU_OFF_CTRL_B, 32'h0000_0000);
    wb_xfer(1'b0, TCU_OFF_COUNT, 32'h0000_0000);
    // Three ticks follow the landed write before the stop lands
    check("write beats count", rd, 32'h0000_0083);
  endtask

  // Any 64 enabled cycles hold exactly 8 taps at /8, any 128 exactly 2 at /64
  task automatic t_prescale();
    wr(TCU_OFF_COUNT, 32'h0000_0000);
    wr(TCU_OFF_CTRL_B, 32'h0000_0002);
    repeat (61) @(posedge core_clk);
    wr(TCU_OFF_CTRL_B, 32'h0000_0000);
    rd_chk("ticks at div 8", TCU_OFF_COUNT, 32'h0000_0008);
    wr(TCU_OFF_COUNT, 32'h0000_0000);
    wr(TCU_OFF_CTRL_B, 32'h0000_0003);
    repeat (125) @(posedge core_clk);
    wr(TCU_OFF_CTRL_B, 32'h0000_0000);
    rd_chk("ticks at div 64", TCU_OFF_COUNT, 32'h0000_0002);
  endtask

  initial begin
    fail_count    = 0;
    num_checks    = 0;
    sys_rst       = 1'b1;
    wb_cyc_i      = 1'b0;
    wb_stb_i      = 1'b0;
    wb_we_i       = 1'b0;
    wb_adr_i      = '0;
    wb_sel_i      = 4'h0;
    wb_dat_i      = '0;
    ext_clock_pin = 1'b0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_stopped();
    t_normal();
    t_match();
    t_ctc();
    t_fast();
    t_phase();
    t_priority();
    t_prescale();
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
endmodule
